// ### mslm_linkpulse_mux.sv
// MAC-side pin mux for serial and link-pulse modes with management and AXI4-Lite access
//
// Register access over AXI4-Lite and the address map were left to the implementer.
`timescale 1ns/100ps
module mslm_linkpulse_mux #(
  parameter int FIFO_DEPTH = 2,
  parameter logic [4:0] PHY_ADDR = 5'h01
) (
  input wire logic aclk, // System clock
  input wire logic aresetn, // Synchronous reset, active low
  input wire logic [11:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write byte enables
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [11:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic config_source_select, // Pin: high selects software configuration
  input wire logic family_select, // Pin: high selects serial or symbol family
  input wire logic link_pulse_select, // Pin: high selects link-pulse interface
  input wire logic speed_select_i, // Speed select pin, input side
  output logic speed_select_o, // Speed select pin, output side
  output logic speed_select_oe, // Speed select pin drive enable
  input wire logic mdc, // Management clock from station manager
  input wire logic mdio_i, // Management data pin, input side
  output logic mdio_o, // Management data pin, output side
  output logic mdio_oe, // Management data pin drive enable
  output logic mii_tx_clk, // Transmit clock pin
  input wire logic mii_tx_en, // Transmit enable pin
  input wire logic [3:0] mii_txd, // Transmit data pins
  input wire logic mii_tx_er, // Transmit error pin
  output logic mii_rx_clk, // Receive clock pin
  output logic mii_rx_dv, // Receive valid pin
  output logic [3:0] mii_rxd, // Receive data pins
  output logic mii_rx_er, // Receive error pin
  output logic mii_crs, // Carrier sense pin
  output logic mii_col, // Collision pin
  output logic link_status_out, // Link status pin
  input wire logic core_tx_clk, // Plain-mode transmit clock from core
  input wire logic core_rx_clk, // Plain-mode receive clock from core
  input wire logic core_rx_dv, // Plain-mode receive valid from core
  input wire logic [3:0] core_rxd, // Plain-mode receive data from core
  input wire logic core_rx_er, // Plain-mode receive error from core
  output logic core_tx_en, // Plain-mode transmit enable to core
  output logic [3:0] core_txd, // Plain-mode transmit data to core
  output logic core_tx_er, // Plain-mode transmit error to core
  input wire logic line_rx_valid, // Received line bit valid
  input wire logic line_rx_bit, // Received line bit
  output logic line_rx_ready, // Receive buffer can take a bit
  input wire logic line_crs, // Line carrier sense
  input wire logic line_col, // Line collision
  input wire logic line_link, // Line link status
  output logic line_tx_strobe, // One-cycle pulse: serial transmit bit taken
  output logic line_tx_en, // Serial transmit enable with strobe
  output logic line_tx_bit, // Serial transmit bit with strobe
  input wire logic line_nlp_rx, // Pulse: link pulse seen on the line
  output logic line_nlp_tx, // Pulse: send one link pulse
  output logic serial_mode_out, // Serial mode active
  output logic pulse_mode_out // Link-pulse mode active
);
  localparam int PW = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
  localparam logic [PW:0] FIFO_FULL = PW'(FIFO_DEPTH) == '0 ? {1'b1, {PW{1'b0}}} : (PW + 1)'(FIFO_DEPTH);
  localparam logic [4:0] HALF_LAST = 5'(mslm_pkg::SER_HALF_CYC - 1);

  if (FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin : g_bad_depth
    $error("FIFO_DEPTH must be a power of two of at least 2");
  end
  if (mslm_pkg::SER_HALF_CYC < 1 || mslm_pkg::SER_HALF_CYC > 32) begin : g_bad_half
    $error("Serial clock half period out of divider range");
  end

  // Pin inputs from the far side pass two flip-flops
  logic [11:0] sync1_q;
  logic [11:0] sync2_q;
  logic mdc_prev_q;
  always_ff @(posedge aclk) begin
    sync1_q <= {config_source_select, family_select, link_pulse_select, speed_select_i,
                mdc, mdio_i, mii_tx_en, mii_tx_er, mii_txd};
    sync2_q <= sync1_q;
    mdc_prev_q <= sync2_q[7];
  end
  wire cfg_sw_s = sync2_q[11];
  wire fam_s = sync2_q[10];
  wire lp_s = sync2_q[9];
  wire speed_pin_s = sync2_q[8];
  wire mdc_s = sync2_q[7];
  wire mdio_s = sync2_q[6];
  wire tx_en_s = sync2_q[5];
  wire tx_er_s = sync2_q[4];
  wire [3:0] txd_s = sync2_q[3:0];
  wire mdc_rise = mdc_s & ~mdc_prev_q;

  // Mode decode
  logic [15:0] ctrl_q;
  wire rate_bit = ctrl_q[mslm_pkg::CTRL_RATE_BIT];
  wire speed_eff = cfg_sw_s ? rate_bit : speed_pin_s;
  wire serial_mode = fam_s & ~lp_s & ~speed_eff;
  wire pulse_mode = ~cfg_sw_s & fam_s & lp_s & speed_pin_s;
  wire link_mode = serial_mode | pulse_mode;

  // Divider for the 10 MHz serial and pulse clocks
  logic [4:0] div_q;
  logic ser_clk_q;
  wire div_end = div_q == HALF_LAST;
  wire ser_rise = div_end & ~ser_clk_q;
  wire ser_fall = div_end & ser_clk_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_q <= 5'h00;
      ser_clk_q <= 1'b0;
    end else begin
      div_q <= div_end ? 5'h00 : div_q + 5'h01;
      if (div_end) begin
        ser_clk_q <= ~ser_clk_q;
      end
    end
  end

  // FIFO_DEPTH-entry receive buffer (two by default) between line and serial receive pins
  logic mem_q [FIFO_DEPTH];
  logic [PW-1:0] wr_ptr_q;
  logic [PW-1:0] rd_ptr_q;
  logic [PW:0] cnt_q;
  assign line_rx_ready = cnt_q != FIFO_FULL;
  wire push = line_rx_valid & line_rx_ready;
  wire fifo_empty = cnt_q == '0;
  wire pop = ser_fall & serial_mode & ~fifo_empty;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + PW'(1);
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + PW'(1);
      end
      cnt_q <= cnt_q + (PW + 1)'(push) - (PW + 1)'(pop);
    end
  end
  always_ff @(posedge aclk) begin
    if (push) begin
      mem_q[wr_ptr_q] <= line_rx_bit;
    end
  end

  // Serial and pulse link state, receive side changes on falling serial edge
  logic ser_dv_q;
  logic ser_rd_q;
  logic nlp_pend_q;
  logic pulse_rx_q;
  logic tx_strobe_q;
  logic tx_en_q;
  logic tx_bit_q;
  logic nlp_tx_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ser_dv_q <= 1'b0;
      ser_rd_q <= 1'b0;
      nlp_pend_q <= 1'b0;
      pulse_rx_q <= 1'b0;
      tx_strobe_q <= 1'b0;
      tx_en_q <= 1'b0;
      tx_bit_q <= 1'b0;
      nlp_tx_q <= 1'b0;
    end else begin
      if (ser_fall) begin
        ser_dv_q <= pop;
        ser_rd_q <= pop ? mem_q[rd_ptr_q] : 1'b0;
        pulse_rx_q <= pulse_mode & nlp_pend_q;
      end
      // A pulse arriving as the pending flag is consumed is kept
      nlp_pend_q <= (line_nlp_rx & pulse_mode) | (nlp_pend_q & ~ser_fall);
      tx_strobe_q <= ser_rise & serial_mode;
      if (ser_rise & serial_mode) begin
        tx_en_q <= tx_en_s;
        tx_bit_q <= txd_s[0];
      end
      nlp_tx_q <= ser_rise & pulse_mode & tx_er_s;
    end
  end
  assign line_tx_strobe = tx_strobe_q;
  assign line_tx_en = tx_en_q;
  assign line_tx_bit = tx_bit_q;
  assign line_nlp_tx = nlp_tx_q;

  // Registered pin multiplexer
  logic tx_clk_q;
  logic rx_clk_q;
  logic rx_dv_q;
  logic [3:0] rxd_q;
  logic rx_er_q;
  logic crs_q;
  logic col_q;
  logic link_status_out_q;
  logic speed_o_q;
  logic speed_oe_q;
  logic ser_q;
  logic pls_q;
  logic core_tx_en_q;
  logic [3:0] core_txd_q;
  logic core_tx_er_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_clk_q <= 1'b0;
      rx_clk_q <= 1'b0;
      rx_dv_q <= 1'b0;
      rxd_q <= 4'h0;
      rx_er_q <= 1'b0;
      crs_q <= 1'b0;
      col_q <= 1'b0;
      link_status_out_q <= 1'b0;
      speed_o_q <= 1'b0;
      speed_oe_q <= 1'b0;
      ser_q <= 1'b0;
      pls_q <= 1'b0;
      core_tx_en_q <= 1'b0;
      core_txd_q <= 4'h0;
      core_tx_er_q <= 1'b0;
    end else begin
      tx_clk_q <= link_mode ? ser_clk_q : core_tx_clk;
      rx_clk_q <= link_mode ? ser_clk_q : core_rx_clk;
      rx_dv_q <= serial_mode ? ser_dv_q : (~pulse_mode & core_rx_dv);
      rxd_q <= serial_mode ? {3'h0, ser_rd_q} : (pulse_mode ? 4'h0 : core_rxd);
      rx_er_q <= serial_mode ? 1'b0 : (pulse_mode ? pulse_rx_q : core_rx_er);
      crs_q <= ~pulse_mode & line_crs;
      col_q <= ~pulse_mode & line_col;
      link_status_out_q <= line_link;
      speed_o_q <= rate_bit;
      speed_oe_q <= cfg_sw_s;
      ser_q <= serial_mode;
      pls_q <= pulse_mode;
      core_tx_en_q <= ~link_mode & tx_en_s;
      core_txd_q <= link_mode ? 4'h0 : txd_s;
      core_tx_er_q <= ~link_mode & tx_er_s;
    end
  end
  assign mii_tx_clk = tx_clk_q;
  assign mii_rx_clk = rx_clk_q;
  assign mii_rx_dv = rx_dv_q;
  assign mii_rxd = rxd_q;
  assign mii_rx_er = rx_er_q;
  assign mii_crs = crs_q;
  assign mii_col = col_q;
  assign link_status_out = link_status_out_q;
  assign speed_select_o = speed_o_q;
  assign speed_select_oe = speed_oe_q;
  assign serial_mode_out = ser_q;
  assign pulse_mode_out = pls_q;
  assign core_tx_en = core_tx_en_q;
  assign core_txd = core_txd_q;
  assign core_tx_er = core_tx_er_q;

  // Status words
  wire [15:0] summ_word = 16'({cfg_sw_s, line_col, line_crs, pulse_mode, serial_mode, speed_eff, line_link});
  wire [15:0] basic_word = mslm_pkg::BASIC_STAT_BASE | (16'(line_link) << mslm_pkg::BASIC_LINK_BIT);

  function automatic logic [15:0] mg_read(input logic [4:0] idx, input logic [15:0] c,
                                          input logic [15:0] b, input logic [15:0] s);
    mg_read = (idx == mslm_pkg::MG_REG_CTRL) ? c : (idx == mslm_pkg::MG_REG_STAT) ? b :
              (idx == mslm_pkg::MG_REG_SUMM) ? s : 16'h0000;
  endfunction

  // Management frame slave, sampled on synchronised clock rising edges
  mslm_pkg::mslm_mg_state_t mg_state_q;
  logic [5:0] pre_cnt_q;
  logic [3:0] bit_cnt_q;
  logic [11:0] hdr_q;
  logic mg_rd_q;
  logic mg_wr_q;
  logic [4:0] mg_reg_q;
  logic [15:0] sh_q;
  logic mdio_o_q;
  logic mdio_oe_q;
  logic mg_we;
  logic [15:0] mg_wdata;
  wire [12:0] hdr_full = {hdr_q, mdio_s};
  wire hdr_ok = hdr_full[12] & (hdr_full[9:5] == PHY_ADDR);
  assign mg_we = mdc_rise & (mg_state_q == mslm_pkg::MG_DATA) & (bit_cnt_q == mslm_pkg::MG_DATA_LAST) & mg_wr_q;
  assign mg_wdata = {sh_q[14:0], mdio_s};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mg_state_q <= mslm_pkg::MG_IDLE;
      pre_cnt_q <= 6'h00;
      bit_cnt_q <= 4'h0;
      hdr_q <= 12'h000;
      mg_rd_q <= 1'b0;
      mg_wr_q <= 1'b0;
      mg_reg_q <= 5'h00;
      sh_q <= 16'h0000;
      mdio_o_q <= 1'b0;
      mdio_oe_q <= 1'b0;
    end else if (mdc_rise) begin
      case (mg_state_q)
        mslm_pkg::MG_IDLE: begin
          if (mdio_s) begin
            pre_cnt_q <= (pre_cnt_q == mslm_pkg::MG_PRE_LEN) ? pre_cnt_q : pre_cnt_q + 6'h01;
          end else if (pre_cnt_q == mslm_pkg::MG_PRE_LEN) begin
            mg_state_q <= mslm_pkg::MG_HDR;
            bit_cnt_q <= 4'h0;
          end else begin
            pre_cnt_q <= 6'h00;
          end
        end
        mslm_pkg::MG_HDR: begin
          hdr_q <= hdr_full[11:0];
          bit_cnt_q <= bit_cnt_q + 4'h1;
          if (bit_cnt_q == mslm_pkg::MG_HDR_LAST) begin
            mg_state_q <= mslm_pkg::MG_TA;
            bit_cnt_q <= 4'h0;
            mg_rd_q <= hdr_ok & (hdr_full[11:10] == mslm_pkg::MG_OP_READ);
            mg_wr_q <= hdr_ok & (hdr_full[11:10] == mslm_pkg::MG_OP_WRITE);
            mg_reg_q <= hdr_full[4:0];
          end
        end
        mslm_pkg::MG_TA: begin
          if (bit_cnt_q == 4'h0) begin
            bit_cnt_q <= 4'h1;
            mdio_oe_q <= mg_rd_q;
            mdio_o_q <= 1'b0;
            sh_q <= mg_read(mg_reg_q, ctrl_q, basic_word, summ_word);
          end else begin
            mg_state_q <= mslm_pkg::MG_DATA;
            bit_cnt_q <= 4'h0;
            mdio_o_q <= mg_rd_q & sh_q[15];
            sh_q <= {sh_q[14:0], 1'b0};
          end
        end
        mslm_pkg::MG_DATA: begin
          bit_cnt_q <= bit_cnt_q + 4'h1;
          sh_q <= mg_wr_q ? mg_wdata : {sh_q[14:0], 1'b0};
          mdio_o_q <= mg_rd_q & sh_q[15];
          if (bit_cnt_q == mslm_pkg::MG_DATA_LAST) begin
            mg_state_q <= mslm_pkg::MG_IDLE;
            pre_cnt_q <= 6'h00;
            mdio_oe_q <= 1'b0;
            mdio_o_q <= 1'b0;
          end
        end
        default: mg_state_q <= mslm_pkg::MG_IDLE;
      endcase
    end
  end
  assign mdio_o = mdio_o_q;
  assign mdio_oe = mdio_oe_q;

  // AXI4-Lite slave
  logic aw_full_q;
  logic w_full_q;
  logic [11:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  assign s_axi_awready = ~aw_full_q & ~bvalid_q;
  assign s_axi_wready = ~w_full_q & ~bvalid_q;
  assign s_axi_arready = ~rvalid_q;
  wire wr_go = aw_full_q & w_full_q & ~bvalid_q;
  wire wr_ctrl = wr_go & (awaddr_q == mslm_pkg::ADDR_CTRL);
  wire wr_ok = wr_ctrl | (wr_go & ((awaddr_q == mslm_pkg::ADDR_STAT) | (awaddr_q == mslm_pkg::ADDR_SUMM)));
  wire [15:0] ctrl_merged = {wstrb_q[1] ? wdata_q[15:8] : ctrl_q[15:8], wstrb_q[0] ? wdata_q[7:0] : ctrl_q[7:0]};
  wire ar_go = s_axi_arvalid & ~rvalid_q;
  wire [31:0] stat_word = {26'h0000000, line_rx_ready, pls_q, ser_q, speed_eff, link_status_out, cfg_sw_s};
  wire rd_hit = (s_axi_araddr == mslm_pkg::ADDR_CTRL) | (s_axi_araddr == mslm_pkg::ADDR_STAT) |
                (s_axi_araddr == mslm_pkg::ADDR_SUMM);
  wire [31:0] rd_word = (s_axi_araddr == mslm_pkg::ADDR_CTRL) ? {16'h0000, ctrl_q} :
                        (s_axi_araddr == mslm_pkg::ADDR_STAT) ? stat_word :
                        (s_axi_araddr == mslm_pkg::ADDR_SUMM) ? {16'h0000, summ_word} : 32'h00000000;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      awaddr_q <= 12'h000;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= mslm_pkg::RESP_OKAY;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= mslm_pkg::RESP_OKAY;
      ctrl_q <= mslm_pkg::CTRL_RST;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        aw_full_q <= 1'b1;
        awaddr_q <= {s_axi_awaddr[11:2], 2'h0};
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_full_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_ok ? mslm_pkg::RESP_OKAY : mslm_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
      // Bus write wins over a management write in the same cycle
      if (wr_ctrl) begin
        ctrl_q <= ctrl_merged;
      end else if (mg_we & (mg_reg_q == mslm_pkg::MG_REG_CTRL)) begin
        ctrl_q <= mg_wdata;
      end
      if (ar_go) begin
        rvalid_q <= 1'b1;
        rdata_q <= rd_word;
        rresp_q <= rd_hit ? mslm_pkg::RESP_OKAY : mslm_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // Counts cycles that the serial clock has held its level
  logic ser_seen_q;
  logic [4:0] half_run_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ser_seen_q <= 1'b0;
      half_run_q <= 5'h00;
    end else begin
      ser_seen_q <= ser_clk_q;
      half_run_q <= (ser_clk_q != ser_seen_q) ? 5'h01 : half_run_q + 5'h01;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  hw_serial_sel_a: assert property (!cfg_sw_s && fam_s && !speed_pin_s && !lp_s |=> ser_q)
    else $error("hardware serial select missed");
  sw_serial_sel_a: assert property (cfg_sw_s && fam_s && !rate_bit && !lp_s |=> ser_q)
    else $error("software serial select missed");
  speed_mirror_a: assert property (cfg_sw_s |=> speed_select_oe && speed_select_o == $past(rate_bit))
    else $error("speed pin does not show rate bit");
  ser_clk_half_a: assert property (ser_clk_q != ser_seen_q |-> half_run_q == HALF_LAST + 5'h01)
    else $error("serial clock half period wrong");
  rx_bit_map_a: assert property (serial_mode && ser_dv_q |=> mii_rx_dv && mii_rxd == {3'h0, $past(ser_rd_q)})
    else $error("serial receive pin map wrong");
  no_err_pin_a: assert property (serial_mode |=> !mii_rx_er && !core_tx_er)
    else $error("error pin active in serial mode");
  pulse_sel_a: assert property (pls_q |-> !$past(cfg_sw_s) && $past(fam_s) && $past(lp_s) && $past(speed_pin_s))
    else $error("link-pulse mode with wrong configuration");
  pulse_rx_map_a: assert property (pulse_mode && $past(pulse_mode) && pulse_rx_q |=> mii_rx_er)
    else $error("pulse receive not on error pin");
  mdio_ta_a: assert property ($rose(mdio_oe) |-> !mdio_o ##1 (mdio_oe [*8]))
    else $error("read turnaround wrong");
  fifo_pass_a: assert property (pop |=> ser_dv_q ##1 (mii_rx_dv || !serial_mode))
    else $error("buffered bit not delivered");
  serial_frame_c: cover property (serial_mode && push ##[1:400] pop);
  pulse_tx_c: cover property (nlp_tx_q);
  mdio_read_c: cover property ($rose(mdio_oe) ##[1:1000] $fell(mdio_oe));
  fifo_full_c: cover property (!line_rx_ready);
endmodule

// ### mslm_linkpulse_mux_tb.sv
// Self-checking bench for the serial and link-pulse pin mux
`timescale 1ns/100ps
module mslm_linkpulse_mux_tb;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, config_source_select, family_select;
  logic link_pulse_select, speed_select_i, speed_select_o, speed_select_oe, mdc, mdio_o, mdio_oe, sta_o;
  logic mii_tx_clk, mii_tx_en, mii_tx_er, mii_rx_clk, mii_rx_dv, mii_rx_er, mii_crs, mii_col, link_status_out;
  logic core_tx_clk, core_rx_clk, core_rx_dv, core_rx_er, core_tx_en, core_tx_er, line_rx_valid, line_rx_bit;
  logic line_rx_ready, line_crs, line_col, line_link, line_tx_strobe, line_tx_en, line_tx_bit, line_nlp_rx;
  logic line_nlp_tx, serial_mode_out, pulse_mode_out, rck_q, ful, b, g, aw, w;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb, mii_txd, mii_rxd, core_rxd, core_txd;
  logic [1:0] s_axi_bresp, s_axi_rresp, r, e;
  logic [63:0] frm;
  wire mdio_i = mdio_oe ? mdio_o : sta_o;
  int err_total, total_checks, cyc, nlp;
  bit q_in[$], q_out[$];
  mslm_linkpulse_mux DUT (.*);
  mslm_mac_model mac (.aclk(aclk), .tx_clk(mii_tx_clk), .pulse_mode(pulse_mode_out), .tx_en(mii_tx_en),
    .txd(mii_txd), .tx_er(mii_tx_er));
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("checks=%0d errors=%0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(negedge aclk);
      aw = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      g = s_axi_bvalid;
      @(posedge aclk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end while (g !== 1'b1);
  endtask
  task automatic rd(input logic [11:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge aclk);
      g = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      aw = s_axi_arready;
      @(posedge aclk);
      if (aw) s_axi_arvalid <= 1'b0;
    end while (g !== 1'b1);
  endtask
  function automatic logic [1:0] mode_exp(input logic [4:0] v);
    mode_exp[0] = v[2] && !v[1] && (v[3] ? !v[4] : !v[0]);
    mode_exp[1] = !v[3] && v[2] && v[1] && v[0];
  endfunction
  // Watches the receive pins and counts link pulses; also cuts a hang short
  always @(negedge aclk) begin
    rck_q <= mii_rx_clk;
    if (!rck_q && mii_rx_clk && mii_rx_dv === 1'b1) q_out.push_back(mii_rxd[0]);
    if (line_tx_strobe === 1'b1) chk({line_tx_en, line_tx_bit}, {mii_tx_en, mii_txd[0]});
    if (line_nlp_tx === 1'b1) nlp++;
    cyc++;
    if (cyc == 40000) begin
      err_total++;
      conclude();
    end
  end
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, config_source_select,
     family_select, link_pulse_select, speed_select_i, mdc, sta_o, core_tx_clk, core_rx_clk, core_rx_dv,
     core_rx_er, line_rx_valid, line_rx_bit, line_crs, line_col, line_link, line_nlp_rx, ful} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, core_rxd} = '0;
    s_axi_wstrb = 4'hf;
    void'($urandom(10104));
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(12'h000);
    chk(d, 32'h3000);
    rd(12'hff0);
    chk({d[29:0], r}, 32'h2); // unmapped
    for (int i = 0; i < 32; i++) begin
      wr(12'h000, i[4] ? 32'h3000 : 32'h1000);
      {config_source_select, family_select, link_pulse_select, speed_select_i} <= i[3:0];
      {line_crs, line_col, line_link} <= 3'($urandom);
      core_rxd <= 4'($urandom);
      repeat (10) @(posedge aclk);
      rd(12'h008);
      @(negedge aclk);
      e = mode_exp(i[4:0]);
      chk(d, {i[3], line_col, line_crs, e, i[3] ? i[4] : i[0], line_link});
      chk({pulse_mode_out, serial_mode_out}, e);
      chk(speed_select_oe, i[3]);
      if (i[3]) chk(speed_select_o, i[4]);
      if (e[0]) chk({mii_rx_er, mii_crs, mii_col, link_status_out}, {1'b0, line_crs, line_col, line_link});
      else if (e[1]) chk(link_status_out, line_link);
      else chk(mii_rxd, core_rxd);
      @(posedge aclk);
    end
    wr(12'h000, 32'h1000);
    {config_source_select, family_select, link_pulse_select, speed_select_i} <= 4'h4;
    repeat (10) @(posedge aclk);
    q_out.delete();
    for (int k = 0; k < 12; k++) begin
      b = 1'($urandom);
      q_in.push_back(b);
      line_rx_bit <= b;
      line_rx_valid <= 1'b1;
      do begin
        @(negedge aclk);
        g = line_rx_ready;
        ful |= !g;
        @(posedge aclk);
      end while (g !== 1'b1);
    end
    line_rx_valid <= 1'b0;
    for (int n = 0; n < 800 && q_out.size() < 12; n++) @(posedge aclk);
    chk(ful, 1'b1); // buffer refused when full
    chk(q_out.size(), 12);
    foreach (q_in[j]) chk(q_out[j], q_in[j]);
    {config_source_select, family_select, link_pulse_select, speed_select_i} <= 4'h7;
    repeat (10) @(posedge aclk);
    nlp = 0;
    line_nlp_rx <= 1'b1;
    @(posedge aclk);
    line_nlp_rx <= 1'b0;
    b = 1'b0;
    repeat (40) begin
      @(negedge aclk);
      b |= mii_rx_er;
    end
    chk(b, 1'b1);
    repeat (400) @(posedge aclk);
    chk(nlp > 0, 1'b1);
    frm = {32'hffffffff, 4'h6, 5'h01, 5'h00, 18'h3ffff};
    for (int i = 0; i < 64; i++) begin
      mdc <= 1'b0;
      sta_o <= frm[63 - i];
      repeat (19) @(posedge aclk);
      @(negedge aclk);
      if (i == 47) chk({mdio_oe, mdio_o}, 2'h2);
      if (i >= 48) d = {d[30:0], mdio_o};
      @(posedge aclk);
      mdc <= 1'b1;
      repeat (20) @(posedge aclk);
    end
    chk(d[15:0], 16'h1000);
    conclude();
  end
endmodule

// ### mslm_mac_model.sv
// MAC-side partner model driving the transmit pins
`timescale 1ns/100ps
module mslm_mac_model (
  input wire logic aclk, // System clock
  input wire logic tx_clk, // Transmit clock from the device
  input wire logic pulse_mode, // Link-pulse mode active
  output logic tx_en = 1'b0, // Transmit enable
  output logic [3:0] txd = 4'h0, // Transmit data
  output logic tx_er = 1'b0 // Transmit error or pulse request
);
  logic clk_q = 1'b0;
  // Changes only after a falling transmit clock, so the device samples a settled bit
  always @(posedge aclk) begin
    clk_q <= tx_clk;
    if (clk_q && !tx_clk) begin
      tx_en <= 1'($urandom);
      txd <= 4'($urandom);
      tx_er <= pulse_mode && ($urandom_range(3) == 0);
    end
  end
endmodule

// ### mslm_pkg.sv
// Constants, types and operation summary for the MAC-side serial and link-pulse pin mux
// Operation
// - With hardware configuration, family select high, speed select low and link-pulse select low pick serial mode.
// - With software configuration, family select high, rate bit zero and link-pulse select low pick serial mode.
// - With software configuration the speed select pin is driven out and shows the rate bit.
// - In serial mode each direction carries one bit stream timed by its own 10 MHz clock; here both clock pins carry the one divider clock ser_clk_q.
// - In serial mode receive clock, valid and data leave on the receive clock, valid and data bit 0 pins.
// - In serial mode the device drives the transmit clock and the MAC drives enable and data bit 0.
// - In serial mode carrier sense and collision use their usual pins and link status stays on its pin.
// - In serial mode no error indication is made or checked, so both error pins are idle.
// - Link-pulse mode needs hardware configuration and family, link-pulse and speed selects all high.
// - In link-pulse mode the device only sends and receives link pulses while the MAC decides when.
// - In link-pulse mode the pins become pulse clocks, pulse transmit in, pulse receive out and signal detect.
// - Link pulses keep one form whatever the speed setting.
// - The management clock and data pins work in every interface mode.
// - The station manager drives the management clock and frames pass over the two-way data pin.
// - Extended registers include a summary status register readable in one management read.
// - Serial mode passes bits straight through with no nibble packing.
package mslm_pkg;
  localparam int CLK_PERIOD_PS = 4000;
  localparam int SER_CLK_PERIOD_PS = 100000;
  localparam int SER_HALF_CYC = (SER_CLK_PERIOD_PS / 2) / CLK_PERIOD_PS;
  localparam int AXI_AW = 12;
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STAT = 12'h004;
  localparam logic [11:0] ADDR_SUMM = 12'h008;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [15:0] CTRL_RST = 16'h3000;
  localparam int CTRL_RATE_BIT = 13;
  localparam logic [15:0] BASIC_STAT_BASE = 16'h7809;
  localparam int BASIC_LINK_BIT = 2;
  localparam int SUM_LINK = 0;
  localparam int SUM_SPEED = 1;
  localparam int SUM_SERIAL = 2;
  localparam int SUM_PULSE = 3;
  localparam int SUM_CRS = 4;
  localparam int SUM_COL = 5;
  localparam int SUM_CFG_SW = 6;
  localparam logic [4:0] MG_REG_CTRL = 5'h00;
  localparam logic [4:0] MG_REG_STAT = 5'h01;
  localparam logic [4:0] MG_REG_SUMM = 5'h11;
  localparam logic [5:0] MG_PRE_LEN = 6'h20;
  localparam logic [3:0] MG_HDR_LAST = 4'hc;
  localparam logic [3:0] MG_DATA_LAST = 4'hf;
  localparam logic [1:0] MG_OP_READ = 2'h2;
  localparam logic [1:0] MG_OP_WRITE = 2'h1;
  typedef enum logic [1:0] {MG_IDLE, MG_HDR, MG_TA, MG_DATA} mslm_mg_state_t;
endpackage
